//--- rtl/tap_pkg.sv
// Constants, carrier types and state codes for the test access port
package tap_pkg;

  localparam int          IR_WIDTH     = 3;
  localparam int          ID_WIDTH     = 32;
  localparam int          BSR_LENGTH   = 128;
  localparam int          RESET_TMS_HI = 5;

  // Pattern loaded into the instruction shift stage on capture
  localparam logic [2:0]  IR_CAPTURE   = 3'h4;

  // Instruction encodings; values are arbitrary
  localparam logic [2:0]  INS_EXTEST   = 3'h0;
  localparam logic [2:0]  INS_SAMPLE   = 3'h1;
  localparam logic [2:0]  INS_IDCODE   = 3'h2;
  localparam logic [2:0]  INS_BYPASS   = 3'h7;

  // Identification word; value is arbitrary
  localparam logic [31:0] ID_VALUE     = 32'h0a5c_0001;

  localparam logic        BYPASS_CAPT  = 1'h0;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tapPins_t;

  typedef enum logic [15:0] {
    ST_RESET   = 16'h0001,
    ST_IDLE    = 16'h0002,
    ST_SEL_DR  = 16'h0004,
    ST_CAP_DR  = 16'h0008,
    ST_SHF_DR  = 16'h0010,
    ST_EX1_DR  = 16'h0020,
    ST_PAU_DR  = 16'h0040,
    ST_EX2_DR  = 16'h0080,
    ST_UPD_DR  = 16'h0100,
    ST_SEL_IR  = 16'h0200,
    ST_CAP_IR  = 16'h0400,
    ST_SHF_IR  = 16'h0800,
    ST_EX1_IR  = 16'h1000,
    ST_PAU_IR  = 16'h2000,
    ST_EX2_IR  = 16'h4000,
    ST_UPD_IR  = 16'h8000
  } tapState_t;

endpackage : tap_pkg

//--- rtl/sync_two_stage.sv
// Two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module sync_two_stage #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,     // System clock
  input  wire logic             reset,   // Synchronous reset, high
  input  wire logic [WIDTH-1:0] asyncIn, // Inputs from outside the domain
  output logic      [WIDTH-1:0] syncOut  // Inputs safe to read
);

  logic [WIDTH-1:0] meta_q;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("sync_two_stage needs WIDTH of at least one");
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule : sync_two_stage

//--- rtl/tap_controller.sv
// Boundary-scan test access port controller with its scan registers
`timescale 1ns/1ps

module tap_controller
  import tap_pkg::*;
#(
  parameter int BSR_LEN = tap_pkg::BSR_LENGTH
) (
  input  wire logic                    clk,      // System clock, 50 MHz
  input  wire logic                    reset,    // Synchronous reset, high
  input  wire tap_pkg::tapPins_t       tapPins,  // Test clock, mode, data in
  input  wire logic [BSR_LEN-1:0]      bsPinIn,  // Pin levels to capture
  output tap_pkg::tapState_t           tapState, // Controller state
  output logic [tap_pkg::IR_WIDTH-1:0] curInstr, // Current instruction
  output logic [BSR_LEN-1:0]           bsOut,    // Latched boundary output
  output logic                         extestEn, // Scan cells drive pins
  output logic                         tdo,      // Serial data out
  output logic                         tdoEn     // Serial out enable
);

  import tap_pkg::*;

  generate
    if (BSR_LEN < 2) begin : g_bad_len
      $error("tap_controller needs BSR_LEN of at least two");
    end
  endgenerate

  localparam int SYNC_W = BSR_LEN + 3;

  tapState_t             state_q;
  tapState_t             state_d;
  logic [SYNC_W-1:0]     syncBus;
  logic                  tckS;
  logic                  tmsS;
  logic                  tdiS;
  logic [BSR_LEN-1:0]    pinS;
  logic                  tckPrev_q;
  logic                  tckRise;
  logic                  tckFall;
  logic [IR_WIDTH-1:0]   irShift_q;
  logic [IR_WIDTH-1:0]   ir_q;
  logic [BSR_LEN-1:0]    bsShift_q;
  logic [BSR_LEN-1:0]    bsUpd_q;
  logic [ID_WIDTH-1:0]   idShift_q;
  logic                  byp_q;
  logic                  tdo_q;
  logic                  tdoEn_q;
  logic                  extest_q;

  // Test clock, mode and data share one synchroniser so that they line up
  sync_two_stage #(
    .WIDTH   (SYNC_W)
  ) u_sync (
    .clk     (clk),
    .reset   (reset),
    .asyncIn ({tapPins.tck, tapPins.tms, tapPins.tdi, bsPinIn}),
    .syncOut (syncBus)
  );

  assign tckS = syncBus[SYNC_W-1];
  assign tmsS = syncBus[SYNC_W-2];
  assign tdiS = syncBus[SYNC_W-3];
  assign pinS = syncBus[BSR_LEN-1:0];

  always_ff @(posedge clk) begin
    if (reset) begin
      tckPrev_q <= 1'b0;
    end else begin
      tckPrev_q <= tckS;
    end
  end

  assign tckRise = tckS & ~tckPrev_q;
  assign tckFall = ~tckS & tckPrev_q;

  // State decodes
  wire inReset = (state_q == ST_RESET);
  wire capDr   = (state_q == ST_CAP_DR);
  wire shfDr   = (state_q == ST_SHF_DR);
  wire updDr   = (state_q == ST_UPD_DR);
  wire capIr   = (state_q == ST_CAP_IR);
  wire shfIr   = (state_q == ST_SHF_IR);
  wire updIr   = (state_q == ST_UPD_IR);

  // Data register selection by the current instruction
  wire selBsr  = (ir_q == INS_EXTEST) || (ir_q == INS_SAMPLE);
  wire selId   = (ir_q == INS_IDCODE);
  wire selByp  = ~selBsr & ~selId;
  wire drOut   = selBsr ? bsShift_q[0] : (selId ? idShift_q[0] : byp_q);

  // Next state on a rising test clock edge
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RESET:  state_d = tmsS ? ST_RESET  : ST_IDLE;
      ST_IDLE:   state_d = tmsS ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_d = tmsS ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_d = tmsS ? ST_EX1_DR : ST_SHF_DR;
      ST_SHF_DR: state_d = tmsS ? ST_EX1_DR : ST_SHF_DR;
      ST_EX1_DR: state_d = tmsS ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_d = tmsS ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_d = tmsS ? ST_UPD_DR : ST_SHF_DR;
      ST_UPD_DR: state_d = tmsS ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_d = tmsS ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: state_d = tmsS ? ST_EX1_IR : ST_SHF_IR;
      ST_SHF_IR: state_d = tmsS ? ST_EX1_IR : ST_SHF_IR;
      ST_EX1_IR: state_d = tmsS ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_d = tmsS ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_d = tmsS ? ST_UPD_IR : ST_SHF_IR;
      ST_UPD_IR: state_d = tmsS ? ST_SEL_DR : ST_IDLE;
      default:   state_d = ST_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_RESET;
    end else if (tckRise) begin
      state_q <= state_d;
    end
  end

  // Instruction shift stage: captured pattern, then shifted toward out
  always_ff @(posedge clk) begin
    if (reset) begin
      irShift_q <= IR_CAPTURE;
    end else if (tckRise && capIr) begin
      irShift_q <= IR_CAPTURE;
    end else if (tckRise && shfIr) begin
      irShift_q <= {tdiS, irShift_q[IR_WIDTH-1:1]};
    end
  end

  // Current instruction changes only in reset or on update; the pin
  // enable reads the same next value so both move in one cycle
  wire [IR_WIDTH-1:0] irNext = inReset ? INS_IDCODE :
                               (tckFall && updIr) ? irShift_q : ir_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      ir_q <= INS_IDCODE;
    end else begin
      ir_q <= irNext;
    end
  end

  // Boundary shift path; pause and exit states leave it alone
  always_ff @(posedge clk) begin
    if (reset) begin
      bsShift_q <= '0;
    end else if (tckRise && capDr && selBsr) begin
      bsShift_q <= pinS;
    end else if (tckRise && shfDr && selBsr) begin
      bsShift_q <= {tdiS, bsShift_q[BSR_LEN-1:1]};
    end
  end

  // Boundary parallel output moves only in data update
  always_ff @(posedge clk) begin
    if (reset) begin
      bsUpd_q <= '0;
    end else if (tckFall && updDr && selBsr) begin
      bsUpd_q <= bsShift_q;
    end
  end

  // Identification register
  always_ff @(posedge clk) begin
    if (reset) begin
      idShift_q <= ID_VALUE;
    end else if (tckRise && capDr && selId) begin
      idShift_q <= ID_VALUE;
    end else if (tckRise && shfDr && selId) begin
      idShift_q <= {tdiS, idShift_q[ID_WIDTH-1:1]};
    end
  end

  // Single-stage bypass register
  always_ff @(posedge clk) begin
    if (reset) begin
      byp_q <= BYPASS_CAPT;
    end else if (tckRise && capDr && selByp) begin
      byp_q <= BYPASS_CAPT;
    end else if (tckRise && shfDr && selByp) begin
      byp_q <= tdiS;
    end
  end

  // Serial output changes on the falling edge, enabled only while shifting
  always_ff @(posedge clk) begin
    if (reset) begin
      tdo_q   <= 1'b0;
      tdoEn_q <= 1'b0;
    end else if (tckFall) begin
      tdo_q   <= shfIr ? irShift_q[0] : drOut;
      tdoEn_q <= shfIr | shfDr;
    end
  end

  // Cells take over the pins only under external test, and let go one cycle after the reset state is entered
  always_ff @(posedge clk) begin
    if (reset) begin
      extest_q <= 1'b0;
    end else begin
      extest_q <= ~inReset && (irNext == INS_EXTEST);
    end
  end

  assign tapState = state_q;
  assign curInstr = ir_q;
  assign bsOut    = bsUpd_q;
  assign extestEn = extest_q;
  assign tdo      = tdo_q;
  assign tdoEn    = tdoEn_q;

endmodule : tap_controller

//--- verification/tap_checker.sv
// Port checks for the test access port controller
`timescale 1ns/1ps
module tap_checker #(
  parameter int BSR_LEN = 128
) (
  input wire logic               clk,      // Clock
  input wire logic               reset,    // Reset
  input wire tap_pkg::tapPins_t  tapPins,  // Test pins
  input wire logic [BSR_LEN-1:0] bsPinIn,  // Pins
  input wire tap_pkg::tapState_t tapState, // State
  input wire logic [2:0]         curInstr, // Instruction
  input wire logic [BSR_LEN-1:0] bsOut,    // Boundary out
  input wire logic               extestEn, // Pins driven
  input wire logic               tdo,      // Serial out
  input wire logic               tdoEn     // Serial enable
);
  import tap_pkg::*;
  logic       tckQ;
  logic [2:0] hiCnt;
  wire        tms  = tapPins.tms;
  wire        rise = tapPins.tck && !tckQ;
  // Counts test clock rises seen with mode high
  always_ff @(posedge clk) begin
    tckQ  <= tapPins.tck;
    hiCnt <= (reset || (rise && !tms)) ? 3'h0 :
             (rise && hiCnt != 3'h5) ? hiCnt + 3'h1 : hiCnt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_five;
    rise && tms && hiCnt == 3'h4 |-> ##[2:5] tapState == ST_RESET;
  endproperty
  a_five: assert property (p_five) else $error("five highs");
  property p_rstHold;
    rise && tms && tapState == ST_RESET |-> (tapState == ST_RESET)[*6];
  endproperty
  a_rstHold: assert property (p_rstHold) else $error("left reset");
  property p_idle;
    rise && !tms && tapState == ST_IDLE |-> (tapState == ST_IDLE)[*6];
  endproperty
  a_idle: assert property (p_idle) else $error("left idle");
  property p_selIr;
    rise && tms && tapState == ST_SEL_IR |-> ##[2:5] tapState == ST_RESET;
  endproperty
  a_selIr: assert property (p_selIr) else $error("select ir");
  property p_instr;
    !$stable(curInstr) |-> tapState inside {ST_UPD_IR, ST_RESET};
  endproperty
  a_instr: assert property (p_instr) else $error("instr moved");
  property p_bsOut;
    !$stable(bsOut) |-> tapState == ST_UPD_DR;
  endproperty
  a_bsOut: assert property (p_bsOut) else $error("bsOut moved");
  property p_extest;
    tapState == ST_RESET && $past(tapState) == ST_RESET |-> !extestEn;
  endproperty
  a_extest: assert property (p_extest) else $error("extest on");
  property p_capIr;
    rise && !tms && tapState == ST_CAP_IR |-> ##[4:12] tdoEn && !tdo;
  endproperty
  a_capIr: assert property (p_capIr) else $error("ir pattern");
  c_updIr: cover property (rise && tapState == ST_UPD_IR);
  c_bsOut: cover property (!$stable(bsOut));
  c_pause: cover property (rise && tms && tapState == ST_PAU_DR);
endmodule : tap_checker

//--- verification/tap_tester.sv
// Behavioural boundary-scan tester driving the test pins
`timescale 1ns/1ps
module tap_tester (
  input  wire logic        clk,  // System clock
  input  wire logic        tdo,  // Serial out of the device
  output tap_pkg::tapPins_t pins // Test clock, mode, data
);
  import tap_pkg::*;
  initial pins = '0;
  // One 160 ns test clock period, four system cycles high and four low.
  // Mode and data settle a cycle before the rise; the step returns once
  // the fall has had three cycles to reach the outputs.
  task automatic step(input logic m, input logic d, output logic q);
    pins.tms = m;
    pins.tdi = d;
    @(posedge clk);
    #1 q = tdo;
    pins.tck = 1'b1;
    repeat (4) @(posedge clk);
    #1 pins.tck = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : step
endmodule : tap_tester

//--- verification/test_tap_controller_state_machine.sv
// Bench for the test access port controller with a reference model
`timescale 1ns/1ps
module test_tap_controller_state_machine;
  import tap_pkg::*;
  logic         clk = 1'b0;
  logic         reset = 1'b1;
  tapPins_t     tapPins;
  logic [127:0] bsPinIn = '0;
  tapState_t    tapState;
  logic [2:0]   curInstr, irSh, code;
  logic [2:0]   cur = INS_IDCODE;
  logic [127:0] bsOut, drSh;
  logic [127:0] bsExp = '0;
  logic         extestEn, tdo, tdoEn, q, expTdo, sel;
  logic         shifting = 1'b0;
  logic [31:0]  rnd = 32'h3;
  int           n_mismatch = 0;
  int           check_count = 0;
  int           s = 0;
  int           k;
  int           n0[16] = '{1,1,3,4,4,6,6,4,1,10,11,11,13,13,11,1};
  int           n1[16] = '{0,2,9,5,5,8,7,8,2,0,12,12,15,14,15,2};
  logic [2:0]   codes[5] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h5};
  logic [29:0]  walk = 30'h3ec2e056;

  always #10 clk = ~clk;

  tap_controller i_dut (
    .clk(clk), .reset(reset), .tapPins(tapPins), .bsPinIn(bsPinIn),
    .tapState(tapState), .curInstr(curInstr), .bsOut(bsOut),
    .extestEn(extestEn), .tdo(tdo), .tdoEn(tdoEn));
  tap_tester i_tester (.clk(clk), .tdo(tdo), .pins(tapPins));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("Mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // One test clock period on the pins and in the model
  task automatic tick(input logic m);
    logic d;
    rnd = lfsr(rnd);
    d = (s == 11) ? code[k % 3] : rnd[0];
    k = k + int'(s == 11);
    i_tester.step(m, d, q);
    if (shifting) chk(q, expTdo);
    sel = cur == INS_EXTEST || cur == INS_SAMPLE;
    if (s == 3) drSh = cur == INS_IDCODE ? ID_VALUE : sel ? bsPinIn : '0;
    if (s == 4) drSh = (drSh >> 1) |
      (128'(d) << (cur == INS_IDCODE ? 31 : sel ? 127 : 0));
    if (s == 10) irSh = IR_CAPTURE;
    if (s == 11) irSh = {d, irSh[2:1]};
    s = m ? n1[s] : n0[s];
    if (s == 15) cur = irSh;
    if (s == 8 && sel) bsExp = drSh;
    if (s == 0) cur = INS_IDCODE;
    shifting = s == 4 || s == 11;
    expTdo = s == 4 ? drSh[0] : irSh[0];
    chk(tapState, 128'h1 << s);
    chk(curInstr, cur);
    chk(bsOut, bsExp);
    chk(extestEn, s != 0 && cur == INS_EXTEST);
    chk(tdoEn, shifting);
    bsPinIn = {4{rnd}};
  endtask : tick

  initial begin
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
    // Test clock rests low while the synchronisers refill
    repeat (3) @(posedge clk);
    #1;
    chk(tapState, ST_RESET);
    chk(curInstr, INS_IDCODE);
    foreach (codes[j]) begin
      code = codes[j];
      k = 0;
      for (int i = 29; i >= 0; i--) tick(walk[i]);
    end
    for (int i = 0; i < 300; i++) begin
      code = rnd[6:4];
      tick(rnd[3]);
    end
    stop_test();
  end

  initial begin
    #500000;
    n_mismatch++;
    stop_test();
  end
endmodule : test_tap_controller_state_machine

bind tap_controller tap_checker #(.BSR_LEN(BSR_LEN)) i_chk (
  .clk(clk), .reset(reset), .tapPins(tapPins), .bsPinIn(bsPinIn),
  .tapState(tapState), .curInstr(curInstr), .bsOut(bsOut),
  .extestEn(extestEn), .tdo(tdo), .tdoEn(tdoEn));
